// ### testbench/fp_coprocessor_host_port_tb.sv
// Purpose: Drives the host end over APB against the device end
// Assumes: Host and device share one clock
// Notes:   Link timing judged by the checker, data here
`timescale 1ns/100ps
`default_nettype none
module fp_coprocessor_host_port_tb;
   import fpc_pkg::*;
   logic        clk = 1'b0;
   logic        reset, psel, penable, pwrite, perr, pready, pslverr;
   logic        write_timing_strap_n, exc_pending;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  round_mode;
   int          mismatches = 0;
   int          checks = 0;
   fpc_link_if fpc_link_if_i ();
   fpc_host fpc_host_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(fpc_link_if_i));
   fpc_device fpc_device_i (.clk(clk), .reset(reset), .link(fpc_link_if_i),
      .write_timing_strap_n(write_timing_strap_n), .round_mode(round_mode),
      .exc_pending(exc_pending));
   fpc_link_assertions fpc_link_assertions_i (.clk(clk), .reset(reset),
      .write_timing_strap_n(write_timing_strap_n), .ads_n(fpc_link_if_i.ads_n),
      .sel(fpc_link_if_i.sel), .wr(fpc_link_if_i.wr), .rdata(fpc_link_if_i.rdata),
      .rdata_oe(fpc_link_if_i.rdata_oe), .rdy_n(fpc_link_if_i.rdy_n),
      .rdy_oe(fpc_link_if_i.rdy_oe), .ready_n(fpc_link_if_i.ready_n),
      .rdy_line_n(fpc_link_if_i.rdy_line_n));
   always #50 clk = ~clk;
   task automatic complete_run;
      if (mismatches == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] ad(input logic [3:0] o, input logic [4:0] d,
                                      input logic [4:0] s);
      return {o, 2'b00, d, s};
   endfunction
   // Entered just after a rising edge; request held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Read at the edge itself, before the design's flops move
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         $display("[ERR] %0t no pready", $time);
      end
      @(posedge clk);
   endtask
   task automatic op(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      apb(1'b1, 8'h10, 32'h8, r);
      apb(1'b1, 8'h08, d, r);
      apb(1'b1, 8'h04, {15'h0, w, a}, r);
      do begin
         apb(1'b0, 8'h10, 32'h0, r);
         n++;
      end while ((r[3] !== 1'b1 || r[1:0] !== 2'b00) && n < 40);
      if (n >= 40) begin
         mismatches++;
         $display("[ERR] %0t command never done", $time);
      end
      apb(1'b0, 8'h0C, 32'h0, r);
   endtask
   task automatic ctx(output logic [31:0] r);
      op(1'b0, ad(FPC_OP_STCTX, 5'd0, 5'd0), 32'h0, r);
   endtask
   task automatic ldctx(input logic [31:0] v);
      logic [31:0] r;
      op(1'b1, ad(FPC_OP_LDCTX, 5'd0, 5'd0), v, r);
   endtask
   task automatic t_reset;
      logic [31:0] r;
      ctx(r);
      chk(r, 32'h01FF0000);
      chk({28'h0, round_mode}, 32'h1);
      apb(1'b0, 8'h40, 32'h0, r);
      chk({r[30:0], perr}, 32'h1);
   endtask
   task automatic t_regs;
      logic [31:0] r;
      logic [4:0]  idx [4] = '{5'd0, 5'd1, 5'd30, 5'd31};
      apb(1'b1, 8'h00, 32'h300, r);
      foreach (idx[i]) begin
         op(1'b1, ad(FPC_OP_LDR, idx[i], 5'd0), {8'h5A, 19'h0, idx[i]}, r);
         op(1'b0, ad(FPC_OP_STR, 5'd0, idx[i]), 32'h0, r);
         chk(r, {8'h5A, 19'h0, idx[i]});
      end
      apb(1'b1, 8'h00, 32'h0, r);
   endtask
   task automatic t_pairs;
      logic [31:0] r;
      op(1'b1, ad(FPC_OP_LDR, 5'd2, 5'd0), 32'h400921FB, r);
      op(1'b1, ad(FPC_OP_LDR, 5'd3, 5'd0), 32'h54442D18, r);
      op(1'b1, ad(FPC_OP_MOVD, 5'd30, 5'd3), 32'h0, r);
      op(1'b0, ad(FPC_OP_STR, 5'd0, 5'd30), 32'h0, r);
      chk(r, 32'h400921FB);
      op(1'b0, ad(FPC_OP_STR, 5'd0, 5'd31), 32'h0, r);
      chk(r, 32'h54442D18);
   endtask
   task automatic t_cmp;
      logic [31:0] r;
      logic [31:0] wv [4] = '{32'h40000000, 32'h3F000000, 32'h7FC00000, 32'h3F800000};
      logic [7:0]  cv [4] = '{8'h01, 8'h00, 8'h45, 8'h40};
      op(1'b1, ad(FPC_OP_LDR, 5'd4, 5'd0), 32'h3F800000, r);
      foreach (wv[i]) begin
         op(1'b1, ad(FPC_OP_CMP, 5'd4, 5'd0), wv[i], r);
         ctx(r);
         chk({24'h0, r[15:8]}, {24'h0, cv[i]});
      end
      op(1'b1, ad(FPC_OP_LDR, 5'd5, 5'd0), 32'h0, r);
      ctx(r);
      chk({16'h0, r[15:0]}, 32'h4001);
   endtask
   task automatic t_context;
      logic [31:0] r;
      logic [31:0] wv [3] = '{32'hC7F01200, 32'h03FF0000, 32'h59005500};
      logic [31:0] ev [3] = '{32'h01F01200, 32'h03FF0000, 32'h03FF0000};
      foreach (wv[i]) begin
         ldctx(wv[i]);
         ctx(r);
         chk(r, ev[i]);
      end
      chk({28'h0, round_mode}, 32'h3);
   endtask
   task automatic t_intr;
      logic [31:0] r;
      op(1'b1, ad(4'h8, 5'd0, 5'd0), 32'h0, r);
      ctx(r);
      chk({r[7:0], 23'h0, exc_pending}, 32'h40000000);
      ldctx(32'h03BF0000);
      op(1'b1, ad(4'h8, 5'd0, 5'd0), 32'h0, r);
      chk({31'h0, exc_pending}, 32'h1);
      ldctx(32'h03FF0000);
      chk({31'h0, exc_pending}, 32'h0);
   endtask
   // Long ready delay keeps the first cycle open so the second goes pipelined
   task automatic t_pipe;
      logic [31:0] r;
      for (int s = 0; s < 2; s++) begin
         write_timing_strap_n <= s[0];
         apb(1'b1, 8'h00, 32'hF01, r);
         apb(1'b1, 8'h10, 32'h8, r);
         apb(1'b1, 8'h08, 32'hC0DE0010, r);
         apb(1'b1, 8'h04, {15'h0, 1'b1, ad(FPC_OP_LDR, 5'd10, 5'd0)}, r);
         apb(1'b1, 8'h08, 32'hC0DE0020, r);
         apb(1'b1, 8'h04, {15'h0, 1'b1, ad(FPC_OP_LDR, 5'd11, 5'd0)}, r);
         chk({31'h0, perr}, 32'h0);
         op(1'b0, ad(FPC_OP_STR, 5'd0, 5'd10), 32'h0, r);
         chk(r, 32'hC0DE0010);
         op(1'b0, ad(FPC_OP_STR, 5'd0, 5'd11), 32'h0, r);
         chk(r, 32'hC0DE0020);
      end
   endtask
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      write_timing_strap_n = 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      t_reset();
      t_regs();
      t_pairs();
      t_cmp();
      t_context();
      t_intr();
      t_pipe();
      complete_run();
   end
   // Whole run needs well under a third of this span
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      $display("[ERR] %0t run hung", $time);
      complete_run();
   end
endmodule
`default_nettype wire

// ### testbench/fpc_link_assertions.sv
// Purpose: Link protocol checks between host and device ends
// Assumes: One clock, synchronous reset
// Notes:   Non-pipelined write lengths judged only with the strap steady for five clocks
`timescale 1ns/100ps
`default_nettype none
module fpc_link_assertions (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        write_timing_strap_n,
   input wire logic        ads_n,
   input wire logic        sel,
   input wire logic        wr,
   input wire logic [31:0] rdata,
   input wire logic        rdata_oe,
   input wire logic        rdy_n,
   input wire logic        rdy_oe,
   input wire logic        ready_n,
   input wire logic        rdy_line_n
);
   logic [3:0] hist_q;
   logic       pend_q;
   logic       pwr_q;
   wire        cyc_end = !ready_n && !rdy_line_n;
   wire        strobe  = !ads_n && sel;
   wire        st_hi   = &{hist_q, write_timing_strap_n};
   wire        st_lo   = ~|{hist_q, write_timing_strap_n};
   wire        pipe_wr = pend_q ? pwr_q : wr;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   always_ff @(posedge clk) begin
      hist_q <= {hist_q[2:0], write_timing_strap_n};
   end
   // Strobe seen while a cycle is open waits for that cycle to end
   always_ff @(posedge clk) begin
      if (reset || cyc_end) begin
         pend_q <= 1'b0;
      end else if (strobe && rdy_oe) begin
         pend_q <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (strobe && rdy_oe && !pend_q) begin
         pwr_q <= wr;
      end
   end
   sequence s_idle_start; strobe && !rdy_oe; endsequence
   sequence s_pipe_start; cyc_end && (pend_q || strobe); endsequence
   sequence s_one_wait; rdy_line_n ##1 !rdy_line_n; endsequence
   sequence s_two_wait; rdy_line_n [*2] ##1 !rdy_line_n; endsequence
   write_fast_a: assert property (s_idle_start ##0 (wr && st_hi) |=> s_one_wait)
      else $error("fast write acknowledge at wrong clock");
   write_slow_a: assert property (s_idle_start ##0 (wr && st_lo) |=> s_two_wait)
      else $error("slow write acknowledge at wrong clock");
   read_wait_a: assert property (s_idle_start ##0 !wr |=> s_two_wait)
      else $error("read acknowledge at wrong clock");
   pipe_write_a: assert property (s_pipe_start ##0 pipe_wr |=> s_one_wait)
      else $error("pipelined write acknowledge at wrong clock");
   drivers_early_a: assert property (s_idle_start ##0 !wr |=> rdy_oe && rdata_oe)
      else $error("read drivers not enabled early");
   no_wr_data_a: assert property (s_idle_start ##0 wr |=> !rdata_oe [*2])
      else $error("data driven on a write");
   hold_read_a: assert property (!rdy_line_n && ready_n && rdata_oe
      |=> !rdy_line_n && $stable(rdata))
      else $error("read data or acknowledge dropped early");
   ack_release_a: assert property (cyc_end |=> rdy_line_n)
      else $error("acknowledge kept after ready");
   ack_driven_a: assert property (!rdy_n |-> rdy_oe)
      else $error("acknowledge low while undriven");
   idle_stays_a: assert property (ready_n && !strobe && !rdy_oe && !pend_q |=> !rdy_oe)
      else $error("cycle began without strobe");
   host_waits_a: assert property (!ready_n |-> !$past(rdy_line_n))
      else $error("host ready before acknowledge");
endmodule
`default_nettype wire

// ### verilog/fpc_defs.svh
// Purpose: Constants shared by both ends of the coprocessor port
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH
`define FPC_SEL_MSB     31
`define FPC_SEL_LSB     28
`define FPC_MODE_MSB    27
`define FPC_MODE_LSB    24
`define FPC_MASK_MSB    23
`define FPC_MASK_LSB    16
`define FPC_CC_MSB      15
`define FPC_CC_LSB      8
`define FPC_STICKY_MSB  7
`define FPC_STICKY_LSB  0
`define FPC_SEL_PARTIAL 4'hC
`define FPC_SEL_FULL    4'h0
`define FPC_MODE_RST    4'h1
`define FPC_MASK_RST    8'hFF
`define FPC_CC_RST      8'h00
`define FPC_STICKY_RST  8'h00
`define FPC_EXC_INVALID 0
`define FPC_EXC_UNDEF   6
`define FPC_WR_FAST     2'h1
`define FPC_WR_SLOW     2'h2
`define FPC_RD_WAIT     2'h2
`define FPC_CTRL_OFS    8'h00
`define FPC_CMD_OFS     8'h04
`define FPC_WDATA_OFS   8'h08
`define FPC_RDATA_OFS   8'h0C
`define FPC_STAT_OFS    8'h10
`define FPC_CTRL_PIPE   0
`define FPC_CMD_WR      16
`define FPC_ST_BUSY     0
`define FPC_ST_QUEUED   1
`define FPC_ST_INTR     2
`define FPC_ST_DONE     3
`endif

// ### verilog/fpc_device.sv
// Purpose: Coprocessor end of the host bus, register file and context
// Assumes: Reset driven in step with clk by the host system
// Notes:   Execution is one simple op per cycle, no arithmetic unit
// Function
// - Every host write carries one instruction
// - Acknowledge each cycle; host ends after it
// - Write data caught at fixed clock only
// - Strap low: non-pipelined write three clocks
// - Reads always get at least one wait
// - Read length independent of the strap
// - Read data held until host ready
// - Drivers on early; data valid at acknowledge
// - Pipelined or plain addressing, per cycle
// - Cycle start from strobe and ready
// - Pipelined write length independent of strap
// - Host keeps reset synchronous to clock
// - 32 singles, paired into 16 doubles
// - Upper word even, lower word odd
// - Host data may feed moves and compares
// - Context register: control in, status out
// - Context field layout in five fields
// - Select 1100 loads mask, compare, sticky
// - Select 0000 also loads rounding mode
// - Unmasked sticky exception raises interrupt
// - Compare field changes only on compares and context loads
`timescale 1ns/100ps
`default_nettype none
`include "fpc_defs.svh"
module fpc_device
   import fpc_pkg::*;
#(
   parameter int NREG = 32
)(
   input  wire logic       clk,
   input  wire logic       reset,
   fpc_link_if.dev         link,
   input  wire logic       write_timing_strap_n,
   output logic      [3:0] round_mode,
   output logic            exc_pending
);
   localparam int AW = $clog2(NREG);

   fpc_dst_t    st_q;
   logic        strap_m_q, strap_q;
   logic [1:0]  cnt_q, need_q;
   logic [15:0] cyc_addr_q, pend_addr_q, start_addr;
   logic        cyc_wr_q, pend_v_q, pend_wr_q, start_wr;
   logic [31:0] regs_q [NREG];
   logic [3:0]  mode_q;
   logic [7:0]  em_q, cc_q, ae_q;
   logic        rdy_n_q, rdy_oe_q, rd_oe_q, intr_q;
   logic [31:0] rdata_q;
   logic        new_req, cyc_end, start, piped, exec;
   fpc_op_t     op;
   logic [AW-1:0] dst, src;
   logic [7:0]  exc;
   logic [7:0]  cc_new;
   logic        is_cmp, bad_op;
   logic [2:0]  cmp_r;

   // Compare two singles: {Z, C2, C0}
   function automatic logic [2:0] fcmp(input logic [31:0] a, input logic [31:0] b);
      logic nan;
      logic lt;
      nan = ((a[30:23] == 8'hFF) & (a[22:0] != 23'h0))
          | ((b[30:23] == 8'hFF) & (b[22:0] != 23'h0));
      lt  = 1'b0;
      if (a[31] != b[31])
         lt = a[31];
      else if (a[31])
         lt = a[30:0] > b[30:0];
      else
         lt = a[30:0] < b[30:0];
      if (nan)
         fcmp = 3'h7;
      else if ((a == b) | ((a[30:0] == 31'h0) & (b[30:0] == 31'h0)))
         fcmp = 3'h4;
      else if (lt)
         fcmp = 3'h1;
      else
         fcmp = 3'h0;
   endfunction

   function automatic logic [1:0] need_of(input logic w, input logic p, input logic s_n);
      if (!w)
         need_of = `FPC_RD_WAIT;
      else if (p | s_n)
         need_of = `FPC_WR_FAST;
      else
         need_of = `FPC_WR_SLOW;
   endfunction

   // Strap is a pin; two flops before use
   always_ff @(posedge clk) begin
      if (reset) begin
         strap_m_q <= 1'b1;
         strap_q   <= 1'b1;
      end else begin
         strap_m_q <= write_timing_strap_n;
         strap_q   <= strap_m_q;
      end
   end

   // Start seen from strobe, or from ready closing the previous cycle
   assign new_req    = ~link.ads_n & link.sel;
   assign cyc_end    = (st_q == FPC_D_ACK) & ~link.ready_n;
   assign piped      = (st_q != FPC_D_IDLE);
   assign start      = ((st_q == FPC_D_IDLE) & new_req)
                     | (cyc_end & (pend_v_q | new_req));
   assign start_addr = pend_v_q ? pend_addr_q : link.addr;
   assign start_wr   = pend_v_q ? pend_wr_q : link.wr;
   // Data sampled one edge after start, ready or not
   assign exec       = (st_q == FPC_D_ACT) & (cnt_q == 2'h1);

   assign op  = fpc_op_t'(cyc_addr_q[15:12]);
   assign dst = cyc_addr_q[5+AW-1:5];
   assign src = cyc_addr_q[AW-1:0];

   always_comb begin
      cmp_r  = 3'h0;
      exc    = 8'h00;
      cc_new = 8'h00;
      is_cmp = 1'b0;
      bad_op = 1'b0;
      case (op)
         FPC_OP_LDR, FPC_OP_MOV, FPC_OP_MOVD, FPC_OP_LDCTX: bad_op = ~cyc_wr_q;
         FPC_OP_STR, FPC_OP_STCTX:                          bad_op = cyc_wr_q;
         FPC_OP_CMP, FPC_OP_CMPR: begin
            bad_op = ~cyc_wr_q;
            is_cmp = cyc_wr_q;
         end
         default: bad_op = 1'b1;
      endcase
      if (is_cmp) begin
         cmp_r  = fcmp(regs_q[dst], (op == FPC_OP_CMP) ? link.wdata : regs_q[src]);
         cc_new = {1'b0, cmp_r[2], 3'h0, cmp_r[1], 1'b0, cmp_r[0]};
         exc[`FPC_EXC_INVALID] = cmp_r[1];
      end
      exc[`FPC_EXC_UNDEF] = bad_op;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q        <= FPC_D_IDLE;
         cnt_q       <= 2'h0;
         need_q      <= 2'h0;
         cyc_addr_q  <= 16'h0;
         cyc_wr_q    <= 1'b0;
         pend_v_q    <= 1'b0;
         pend_addr_q <= 16'h0;
         pend_wr_q   <= 1'b0;
         rdy_n_q     <= 1'b1;
         rdy_oe_q    <= 1'b0;
         rd_oe_q     <= 1'b0;
      end else begin
         if (start) begin
            st_q       <= FPC_D_ACT;
            cnt_q      <= 2'h1;
            need_q     <= need_of(start_wr, piped, strap_q);
            cyc_addr_q <= start_addr;
            cyc_wr_q   <= start_wr;
            pend_v_q   <= 1'b0;
            rdy_n_q    <= 1'b1;
            rdy_oe_q   <= 1'b1;
            rd_oe_q    <= ~start_wr;
         end else if (cyc_end) begin
            st_q     <= FPC_D_IDLE;
            rdy_n_q  <= 1'b1;
            rdy_oe_q <= 1'b0;
            rd_oe_q  <= 1'b0;
         end else begin
            if (piped & new_req & ~pend_v_q) begin
               pend_v_q    <= 1'b1;
               pend_addr_q <= link.addr;
               pend_wr_q   <= link.wr;
            end
            if (st_q == FPC_D_ACT) begin
               if (cnt_q == need_q) begin
                  rdy_n_q <= 1'b0;
                  st_q    <= FPC_D_ACK;
               end else begin
                  cnt_q <= cnt_q + 2'h1;
               end
            end
         end
      end
   end

   // Register file; double pair moves keep upper word in the even slot
   always_ff @(posedge clk) begin
      if (exec) begin
         case (op)
            FPC_OP_LDR:  if (cyc_wr_q) regs_q[dst] <= link.wdata;
            FPC_OP_MOV:  if (cyc_wr_q) regs_q[dst] <= regs_q[src];
            FPC_OP_MOVD: if (cyc_wr_q) begin
               regs_q[{dst[AW-1:1], 1'b0}] <= regs_q[{src[AW-1:1], 1'b0}];
               regs_q[{dst[AW-1:1], 1'b1}] <= regs_q[{src[AW-1:1], 1'b1}];
            end
            default: ;
         endcase
      end
   end

   // Read result loaded early; stands until the cycle closes
   always_ff @(posedge clk) begin
      if (reset)
         rdata_q <= 32'h0;
      else if (exec)
         case (op)
            FPC_OP_STR:   rdata_q <= regs_q[src];
            FPC_OP_STCTX: rdata_q <= {4'h0, mode_q, em_q, cc_q, ae_q};
            default:      rdata_q <= 32'h0;
         endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mode_q <= `FPC_MODE_RST;
         em_q   <= `FPC_MASK_RST;
         cc_q   <= `FPC_CC_RST;
         ae_q   <= `FPC_STICKY_RST;
      end else if (exec) begin
         if ((op == FPC_OP_LDCTX) & cyc_wr_q) begin
            case (link.wdata[`FPC_SEL_MSB:`FPC_SEL_LSB])
               `FPC_SEL_PARTIAL: begin
                  em_q <= link.wdata[`FPC_MASK_MSB:`FPC_MASK_LSB];
                  cc_q <= link.wdata[`FPC_CC_MSB:`FPC_CC_LSB];
                  ae_q <= link.wdata[`FPC_STICKY_MSB:`FPC_STICKY_LSB];
               end
               `FPC_SEL_FULL: begin
                  mode_q <= link.wdata[`FPC_MODE_MSB:`FPC_MODE_LSB];
                  em_q   <= link.wdata[`FPC_MASK_MSB:`FPC_MASK_LSB];
                  cc_q   <= link.wdata[`FPC_CC_MSB:`FPC_CC_LSB];
                  ae_q   <= link.wdata[`FPC_STICKY_MSB:`FPC_STICKY_LSB];
               end
               default: ;
            endcase
         end else begin
            ae_q <= ae_q | exc;
            if (is_cmp)
               cc_q <= cc_new;
         end
      end
   end

   // Interrupt follows the sticky field one clock later
   always_ff @(posedge clk) begin
      if (reset)
         intr_q <= 1'b0;
      else
         intr_q <= |(ae_q & ~em_q);
   end

   assign link.rdy_n    = rdy_n_q;
   assign link.rdy_oe   = rdy_oe_q;
   assign link.rdata    = rdata_q;
   assign link.rdata_oe = rd_oe_q;
   assign link.intr     = intr_q;
   assign round_mode    = mode_q;
   assign exc_pending   = intr_q;
endmodule
`default_nettype wire

// ### verilog/fpc_host.sv
// Purpose: Host end: runs link cycles ordered over APB
// Assumes: Device on the same clock
// Notes:   One queued command; pipelined issue optional
`timescale 1ns/100ps
`default_nettype none
`include "fpc_defs.svh"
module fpc_host
   import fpc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   fpc_link_if.host         link
);
   fpc_hst_t    st_q;
   logic        pipe_q;
   logic [3:0]  dly_q, dcnt_q;
   logic [31:0] wreg_q, rreg_q, prdata_q;
   logic        q_v_q, q_wr_q, nxt_v_q, nxt_wr_q, cur_wr_q, done_q;
   logic [15:0] q_addr_q;
   logic [31:0] q_wdata_q, nxt_wdata_q;
   logic        pready_q, pslverr_q;
   logic        ads_n_q, sel_q, wr_q, ready_n_q;
   logic [15:0] addr_q;
   logic [31:0] wdata_q;
   logic        take, wr_cmd, issue_p, cyc_done;

   function automatic logic [2:0] dec(input logic [7:0] a);
      case (a)
         `FPC_CTRL_OFS:  dec = 3'h1;
         `FPC_CMD_OFS:   dec = 3'h2;
         `FPC_WDATA_OFS: dec = 3'h3;
         `FPC_RDATA_OFS: dec = 3'h4;
         `FPC_STAT_OFS:  dec = 3'h5;
         default:        dec = 3'h0;
      endcase
   endfunction

   assign take     = psel & penable & pready_q;
   assign wr_cmd   = take & pwrite & (dec(paddr) == 3'h2) & ~q_v_q;
   assign issue_p  = (st_q == FPC_H_WAIT) & pipe_q & q_v_q & ~nxt_v_q;
   // Data is only trusted while the acknowledge is seen low
   assign cyc_done = (st_q == FPC_H_RDY) & ~link.rdy_line_n;

   always_ff @(posedge clk) begin
      if (reset) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ((dec(paddr) == 3'h0)
                      | (pwrite & (dec(paddr) == 3'h2) & q_v_q));
         case (dec(paddr))
            3'h1:    prdata_q <= {20'h0, dly_q, 7'h0, pipe_q};
            3'h3:    prdata_q <= wreg_q;
            3'h4:    prdata_q <= rreg_q;
            3'h5:    prdata_q <= {28'h0, done_q, link.intr, q_v_q,
                                  (st_q != FPC_H_IDLE) | q_v_q};
            default: prdata_q <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pipe_q <= 1'b0;
         dly_q  <= 4'h0;
         wreg_q <= 32'h0;
         done_q <= 1'b0;
      end else begin
         if (take & pwrite & (dec(paddr) == 3'h1)) begin
            pipe_q <= pwdata[`FPC_CTRL_PIPE];
            dly_q  <= pwdata[11:8];
         end
         if (take & pwrite & (dec(paddr) == 3'h3))
            wreg_q <= pwdata;
         // Completion beats a clear in the same cycle
         if (cyc_done)
            done_q <= 1'b1;
         else if (take & pwrite & (dec(paddr) == 3'h5) & pwdata[`FPC_ST_DONE])
            done_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= FPC_H_IDLE;
         q_v_q       <= 1'b0;
         q_wr_q      <= 1'b0;
         q_addr_q    <= 16'h0;
         q_wdata_q   <= 32'h0;
         nxt_v_q     <= 1'b0;
         nxt_wr_q    <= 1'b0;
         nxt_wdata_q <= 32'h0;
         cur_wr_q    <= 1'b0;
         dcnt_q      <= 4'h0;
         rreg_q      <= 32'h0;
         ads_n_q     <= 1'b1;
         sel_q       <= 1'b0;
         wr_q        <= 1'b0;
         addr_q      <= 16'h0;
         wdata_q     <= 32'h0;
         ready_n_q   <= 1'b1;
      end else begin
         ads_n_q <= 1'b1;
         if (wr_cmd) begin
            q_v_q     <= 1'b1;
            q_addr_q  <= pwdata[15:0];
            q_wr_q    <= pwdata[`FPC_CMD_WR];
            q_wdata_q <= wreg_q;
         end
         case (st_q)
            FPC_H_IDLE: begin
               if (q_v_q) begin
                  // Each instruction goes out as a read or write cycle, per its command bit
                  ads_n_q  <= 1'b0;
                  sel_q    <= 1'b1;
                  addr_q   <= q_addr_q;
                  wr_q     <= q_wr_q;
                  cur_wr_q <= q_wr_q;
                  wdata_q  <= q_wdata_q;
                  q_v_q    <= 1'b0;
                  st_q     <= FPC_H_ADDR;
               end
            end
            FPC_H_ADDR: st_q <= FPC_H_WAIT;
            FPC_H_WAIT: begin
               if (issue_p) begin
                  ads_n_q     <= 1'b0;
                  addr_q      <= q_addr_q;
                  wr_q        <= q_wr_q;
                  nxt_v_q     <= 1'b1;
                  nxt_wr_q    <= q_wr_q;
                  nxt_wdata_q <= q_wdata_q;
                  q_v_q       <= 1'b0;
               end
               // Ready only follows the device acknowledge
               if (~link.rdy_line_n) begin
                  if (dcnt_q == dly_q) begin
                     ready_n_q <= 1'b0;
                     st_q      <= FPC_H_RDY;
                  end else begin
                     dcnt_q <= dcnt_q + 4'h1;
                  end
               end
            end
            FPC_H_RDY: begin
               ready_n_q <= 1'b1;
               dcnt_q    <= 4'h0;
               if (~cur_wr_q)
                  rreg_q <= link.rdata;
               if (nxt_v_q) begin
                  nxt_v_q  <= 1'b0;
                  cur_wr_q <= nxt_wr_q;
                  wdata_q  <= nxt_wdata_q;
                  st_q     <= FPC_H_WAIT;
               end else begin
                  sel_q <= 1'b0;
                  st_q  <= FPC_H_IDLE;
               end
            end
            default: st_q <= FPC_H_IDLE;
         endcase
      end
   end

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign link.ads_n    = ads_n_q;
   assign link.sel      = sel_q;
   assign link.wr       = wr_q;
   assign link.addr     = addr_q;
   assign link.wdata    = wdata_q;
   assign link.ready_n  = ready_n_q;
endmodule
`default_nettype wire

// ### verilog/fpc_link_if.sv
// Purpose: Bus between host and coprocessor
// Assumes: One clock for both ends
// Notes:   Acknowledge line pulled high when not driven
`timescale 1ns/100ps
`default_nettype none
interface fpc_link_if;
   logic        ads_n;
   logic        sel;
   logic        wr;
   logic [15:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        rdata_oe;
   logic        rdy_n;
   logic        rdy_oe;
   logic        ready_n;
   logic        intr;
   logic        rdy_line_n;
   assign rdy_line_n = rdy_oe ? rdy_n : 1'b1;
   modport dev (input ads_n, sel, wr, addr, wdata, ready_n,
                output rdata, rdata_oe, rdy_n, rdy_oe, intr);
   modport host (output ads_n, sel, wr, addr, wdata, ready_n,
                 input rdata, rdata_oe, rdy_line_n, intr);
endinterface
`default_nettype wire

// ### verilog/fpc_pkg.sv
// Purpose: Types for the coprocessor port
// Assumes: Nothing
// Notes:   Opcode sits in link address bits 15:12
package fpc_pkg;
   typedef enum logic [3:0] {
      FPC_OP_LDR   = 4'h0,
      FPC_OP_STR   = 4'h1,
      FPC_OP_MOV   = 4'h2,
      FPC_OP_MOVD  = 4'h3,
      FPC_OP_CMP   = 4'h4,
      FPC_OP_CMPR  = 4'h5,
      FPC_OP_LDCTX = 4'h6,
      FPC_OP_STCTX = 4'h7
   } fpc_op_t;
   typedef enum logic [2:0] {
      FPC_D_IDLE = 3'h1,
      FPC_D_ACT  = 3'h2,
      FPC_D_ACK  = 3'h4
   } fpc_dst_t;
   typedef enum logic [3:0] {
      FPC_H_IDLE = 4'h1,
      FPC_H_ADDR = 4'h2,
      FPC_H_WAIT = 4'h4,
      FPC_H_RDY  = 4'h8
   } fpc_hst_t;
endpackage
